// *** rtl/sys_pin_regs.svh ***
// Purpose: constants for the system pin control logic
// Assumes: 16-bit control words, 16-bit program address
// Notes: none
`ifndef SYS_PIN_REGS_SVH
`define SYS_PIN_REGS_SVH
`define CTRL_CLK_OUT_SELECT_BIT 14
`define CTRL_TWO_BOOT_ENABLE_BIT 3
`define PROG_COUNTER_RESET_VALUE 16'h0000
`define CTRL_RESET_VALUE 16'h0000
`define CTRL_TWO_RESET_VALUE 16'h0000
`define WD_RESET_PULSE_CYCLES 8'h04
`define GPIO_COUNT 40
`endif

// *** rtl/sys_pin_pkg.sv ***
// Purpose: types for the system pin control logic
// Assumes: nothing
// Notes: none
package sys_pin_pkg;
    typedef logic [15:0] word_t;
    typedef enum logic [1:0] {
        RUN_HELD = 2'b01,
        RUN_GO = 2'b10
    } run_state_t;
endpackage : sys_pin_pkg

// *** rtl/system_pin_control_logic.sv ***
// Purpose: reset, fault, interrupt, clock-out and boot-pin control
// Assumes: one 50 MHz clock; pins sampled through three flip-flops
// Notes: control words come in as ports; no software bus
//
// Behaviour
// - While the reset pin is low, execution halts, the program counter is zero and the state is RUN_HELD.
// - When the reset pin rises, fetch starts at program address zero.
// - A watchdog overflow makes a reset pulse that is driven onto the reset pin.
// - A falling edge on fault input A interrupts and floats all PWM pins of event manager A.
// - A falling edge on fault input B interrupts and floats all PWM pins of event manager B.
// - Both user interrupt inputs are edge detected with software-selected polarity.
// - The second user interrupt input can instead start a conversion, per irq_two_mode_start.
// - The clock output drives CPU clock or watchdog clock per select bit 14.
// - The boot-enable pin is sampled in reset into bit 3 of the second control word, then drives the flag.
// - Mask ROM variants have no boot mode and the pin is only the flag output.
// - After any reset every general-purpose pin is an input.
// - The oscillator output floats while the test output-disable is low.
// - Output-disable holds only with test reset low, emulator pin zero high, disable pin low.
`include "sys_pin_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module system_pin_control_logic #(
    parameter bit HAS_FLASH = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic system_reset_pin_in,
    input wire logic boot_enable_pin_in,
    output logic system_reset_pin_out,
    output logic system_reset_pin_oe,
    input wire logic watchdog_overflow,
    input wire logic watchdog_tick_clock,
    input wire logic drive_fault_input_a,
    input wire logic drive_fault_input_b,
    input wire logic user_irq_one,
    input wire logic user_irq_two,
    input wire logic irq_one_rising,
    input wire logic irq_two_rising,
    input wire logic irq_two_mode_start,
    input wire logic fault_clear_a,
    input wire logic fault_clear_b,
    input wire logic irq_clear_one,
    input wire logic irq_clear_two,
    input wire sys_pin_pkg::word_t sys_ctrl_status_reg,
    input wire logic advance,
    input wire logic [15:0] branch_target,
    input wire logic branch,
    input wire logic ext_flag_value,
    input wire logic test_reset,
    input wire logic emulator_pin_zero,
    input wire logic test_output_disable,
    output logic cpu_running,
    output sys_pin_pkg::word_t program_counter,
    output sys_pin_pkg::word_t sys_ctrl_status_reg_two,
    output logic fault_irq_a,
    output logic fault_irq_b,
    output logic pwm_float_a,
    output logic pwm_float_b,
    output logic user_irq_one_flag,
    output logic user_irq_two_flag,
    output logic conversion_start_input,
    output logic clock_output_pin,
    output logic external_flag_output,
    output logic external_flag_oe,
    output logic oscillator_output_oe,
    output logic all_outputs_float,
    output logic [`GPIO_COUNT-1:0] gpio_dir_out
);
    import sys_pin_pkg::*;

    ////////////////////////////////////////////////////////////////////
    logic rst_meta_reg, rst_sync_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire rstn = rst_sync_reg;

    ////////////////////////////////////////////////////////////////////
    // Pin sampling: a level change counts once stages two and three agree
    // Bit 8 is the boot strap, shared with the flag driver; it is only
    // trusted while the flag driver is off, which is the whole reset time
    localparam int NPIN = 9;
    wire [NPIN-1:0] pin_raw = {
        boot_enable_pin_in, system_reset_pin_in,
        drive_fault_input_a, drive_fault_input_b,
        user_irq_one, user_irq_two,
        test_reset, emulator_pin_zero, test_output_disable
    };
    logic [NPIN-1:0] s1_reg, s2_reg, s3_reg, stable_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= '1;
            s2_reg <= '1;
            s3_reg <= '1;
            stable_reg <= '1;
        end else begin
            s1_reg <= pin_raw;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_reg <= (s2_reg & s3_reg) | (stable_reg & (s2_reg | s3_reg));
        end
    end
    logic [NPIN-1:0] prev_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) prev_reg <= '1;
        else prev_reg <= stable_reg;
    end
    wire [NPIN-1:0] fall = prev_reg & ~stable_reg;
    wire [NPIN-1:0] rise = ~prev_reg & stable_reg;
    wire boot_pin_level = stable_reg[8];
    wire rst_pin_level = stable_reg[7];
    wire trst_level = stable_reg[2];
    wire emu_zero_level = stable_reg[1];
    wire off_level = stable_reg[0];

    ////////////////////////////////////////////////////////////////////
    // Watchdog reset pulse, driven low onto the open-drain reset pin
    logic [7:0] wd_count_reg, wd_count_next;
    assign wd_count_next = watchdog_overflow ? `WD_RESET_PULSE_CYCLES :
        (wd_count_reg != 8'h00) ? wd_count_reg - 8'h01 : 8'h00;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) wd_count_reg <= 8'h00;
        else wd_count_reg <= wd_count_next;
    end
    wire wd_pulse = wd_count_reg != 8'h00;
    // Internal reset also follows our own pulse so it acts even if the pin is loaded
    wire in_reset = !rst_pin_level || wd_pulse;

    ////////////////////////////////////////////////////////////////////
    // Execution control
    run_state_t state_reg, state_next;
    word_t pc_next;
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            RUN_HELD: if (!in_reset) state_next = RUN_GO;
            RUN_GO: if (in_reset) state_next = RUN_HELD;
        endcase
    end
    assign pc_next = (in_reset || state_reg == RUN_HELD) ? `PROG_COUNTER_RESET_VALUE :
        branch ? branch_target : advance ? program_counter + 16'h0001 : program_counter;

    // Boot strap is caught by a clocked process while reset holds;
    // the last sample before release is the one that stays
    wire boot_bit = HAS_FLASH ? boot_pin_level : 1'b0;
    word_t sys_ctrl_status_reg_two_next;
    always_comb begin
        sys_ctrl_status_reg_two_next = sys_ctrl_status_reg_two;
        if (in_reset) begin
            sys_ctrl_status_reg_two_next = `CTRL_TWO_RESET_VALUE;
            if (HAS_FLASH) sys_ctrl_status_reg_two_next[`CTRL_TWO_BOOT_ENABLE_BIT] = boot_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Sticky event flags; a new edge wins over a clear in the same cycle
    wire pol1_rise = irq_one_rising;
    wire edge_one = pol1_rise ? rise[4] : fall[4];
    wire edge_two = irq_two_rising ? rise[3] : fall[3];
    wire off_active = !trst_level && emu_zero_level && !off_level;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= RUN_HELD;
            program_counter <= `PROG_COUNTER_RESET_VALUE;
            sys_ctrl_status_reg_two <= `CTRL_TWO_RESET_VALUE;
            cpu_running <= 1'b0;
            fault_irq_a <= 1'b0;
            fault_irq_b <= 1'b0;
            pwm_float_a <= 1'b0;
            pwm_float_b <= 1'b0;
            user_irq_one_flag <= 1'b0;
            user_irq_two_flag <= 1'b0;
            conversion_start_input <= 1'b0;
            system_reset_pin_out <= 1'b0;
            system_reset_pin_oe <= 1'b0;
            external_flag_output <= 1'b0;
            external_flag_oe <= 1'b0;
            oscillator_output_oe <= 1'b1;
            all_outputs_float <= 1'b0;
            gpio_dir_out <= '0;
        end else begin
            state_reg <= state_next;
            program_counter <= pc_next;
            sys_ctrl_status_reg_two <= sys_ctrl_status_reg_two_next;
            cpu_running <= (state_next == RUN_GO);
            fault_irq_a <= fall[6] | (fault_irq_a & ~fault_clear_a);
            fault_irq_b <= fall[5] | (fault_irq_b & ~fault_clear_b);
            pwm_float_a <= fall[6] | (pwm_float_a & ~fault_clear_a);
            pwm_float_b <= fall[5] | (pwm_float_b & ~fault_clear_b);
            user_irq_one_flag <= edge_one | (user_irq_one_flag & ~irq_clear_one);
            user_irq_two_flag <= (edge_two & ~irq_two_mode_start) |
                (user_irq_two_flag & ~irq_clear_two);
            conversion_start_input <= edge_two & irq_two_mode_start;
            system_reset_pin_out <= 1'b0;
            system_reset_pin_oe <= wd_pulse && !off_active;
            external_flag_output <= ext_flag_value;
            external_flag_oe <= !in_reset && !off_active;
            oscillator_output_oe <= off_level && !off_active;
            all_outputs_float <= off_active;
            gpio_dir_out <= in_reset ? '0 : gpio_dir_out;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock output: a glitch-free mux is out of scope; the select is
    // registered so it changes only on a CPU clock edge
    logic sel_reg;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) sel_reg <= 1'b0;
        else sel_reg <= sys_ctrl_status_reg[`CTRL_CLK_OUT_SELECT_BIT];
    end
    // Forwarded clock cannot come from a flop; the select itself does
    assign clock_output_pin = sel_reg ? watchdog_tick_clock : clock;
endmodule : system_pin_control_logic
`default_nettype wire

// *** sim/pin_board_model.sv ***
// Purpose: board circuits around the pins
// Assumes: reset pin pulled up
// Notes: none
`timescale 1ns/1ps
`default_nettype none
module pin_board_model (
    input wire logic press_reset,
    input wire logic drv_oe,
    input wire logic drv_out,
    input wire logic [3:0] want,
    output wire logic rst_pin,
    output wire logic [3:0] pins
);
    // Open drain: button or device pulls low, else the pull-up wins
    assign rst_pin = !press_reset && !(drv_oe && !drv_out);
    assign pins = want;
endmodule : pin_board_model
`default_nettype wire

// *** sim/system_pin_chk.sv ***
// Purpose: port checks for the pin control block
// Assumes: pins act within eight clocks
// Notes: bound below
`include "sys_pin_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module system_pin_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic system_reset_pin_out,
    input wire logic system_reset_pin_oe,
    input wire logic drive_fault_input_a,
    input wire logic drive_fault_input_b,
    input wire logic fault_clear_a,
    input wire logic fault_irq_a,
    input wire logic pwm_float_a,
    input wire logic pwm_float_b,
    input wire sys_pin_pkg::word_t sys_ctrl_status_reg,
    input wire logic watchdog_tick_clock,
    input wire logic clock_output_pin,
    input wire logic cpu_running,
    input wire sys_pin_pkg::word_t program_counter,
    input wire logic [`GPIO_COUNT-1:0] gpio_dir_out,
    input wire logic conversion_start_input,
    input wire logic oscillator_output_oe,
    input wire logic all_outputs_float,
    input wire logic test_reset,
    input wire logic emulator_pin_zero,
    input wire logic test_output_disable
);
    import sys_pin_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    wire logic off_req = !test_reset && emulator_pin_zero && !test_output_disable;
    halt_pc_a: assert property (!cpu_running |-> program_counter == 16'h0000)
        else $error("pc moved while halted");
    wd_pulse_a: assert property ($rose(system_reset_pin_oe) |-> system_reset_pin_oe[*4] ##1 !system_reset_pin_oe)
        else $error("watchdog pulse length wrong");
    wd_halt_a: assert property ($rose(system_reset_pin_oe) |-> ##[1:8] !cpu_running)
        else $error("watchdog pulse did not halt");
    drain_low_a: assert property (system_reset_pin_oe |-> !system_reset_pin_out)
        else $error("reset pin driven high");
    fault_a_a: assert property ($fell(drive_fault_input_a) |-> ##[1:8] (pwm_float_a && fault_irq_a))
        else $error("fault a not taken");
    fault_b_a: assert property ($fell(drive_fault_input_b) |-> ##[1:8] pwm_float_b)
        else $error("fault b not taken");
    float_hold_a: assert property (pwm_float_a && !fault_clear_a |=> pwm_float_a)
        else $error("float a dropped");
    clk_sel_a: assert property ($past(sys_ctrl_status_reg[14]) |-> clock_output_pin == watchdog_tick_clock)
        else $error("clock output not watchdog clock");
    conv_pulse_a: assert property (conversion_start_input |=> !conversion_start_input)
        else $error("conversion start too long");
    gpio_in_a: assert property ($rose(cpu_running) |-> gpio_dir_out == '0)
        else $error("gpio not input");
    off_on_a: assert property (off_req[*6] |-> all_outputs_float && !oscillator_output_oe)
        else $error("outputs not floated");
    off_none_a: assert property ((!off_req)[*6] |-> !all_outputs_float)
        else $error("outputs floated");
    cover property ($rose(pwm_float_b));
    cover property (conversion_start_input);
    cover property ($rose(system_reset_pin_oe));
endmodule : system_pin_chk
bind system_pin_control_logic system_pin_chk u_chk (.*);
`default_nettype wire

// *** sim/test_system_pin_control_logic.sv ***
// Purpose: scenarios for the pin control block
// Assumes: board model drives the pins
// Notes: none
`include "sys_pin_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module test_system_pin_control_logic;
    import sys_pin_pkg::*;
    logic clock = 1'b0, resetn = 1'b0, watchdog_overflow = 1'b0, watchdog_tick_clock = 1'b0;
    logic fault_clear_a = 1'b0, fault_clear_b = 1'b0, irq_clear_one = 1'b0, irq_clear_two = 1'b0;
    logic irq_one_rising = 1'b0, irq_two_rising = 1'b0, irq_two_mode_start = 1'b1, press = 1'b0;
    logic advance = 1'b0, branch = 1'b0, ext_flag_value = 1'b0, test_reset = 1'b1;
    logic emulator_pin_zero = 1'b1, test_output_disable = 1'b1;
    logic [3:0] want = 4'hf;
    logic [15:0] branch_target = 16'h0000;
    word_t sys_ctrl_status_reg = 16'h0000;
    word_t program_counter, sys_ctrl_status_reg_two;
    wire logic system_reset_pin_in, drive_fault_input_a, drive_fault_input_b;
    wire logic user_irq_one, user_irq_two;
    logic boot_enable_pin_in = 1'b1;
    logic system_reset_pin_out, system_reset_pin_oe, cpu_running, fault_irq_a, fault_irq_b;
    logic pwm_float_a, pwm_float_b, user_irq_one_flag, user_irq_two_flag, conversion_start_input;
    logic clock_output_pin, external_flag_output, external_flag_oe, oscillator_output_oe;
    logic all_outputs_float;
    logic [`GPIO_COUNT-1:0] gpio_dir_out;
    int error_cnt = 0, total_checks = 0, n;
    wire logic [5:0] watch = {!cpu_running, cpu_running, pwm_float_a, pwm_float_b,
        user_irq_one_flag, system_reset_pin_oe};
    pin_board_model u_board (.press_reset(press), .drv_oe(system_reset_pin_oe),
        .drv_out(system_reset_pin_out), .want(want), .rst_pin(system_reset_pin_in),
        .pins({drive_fault_input_a, drive_fault_input_b, user_irq_one, user_irq_two}));
    system_pin_control_logic u_dut (.*);
    always #10 clock = ~clock;
    always @(posedge clock) watchdog_tick_clock <= ~watchdog_tick_clock;
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : wrap_up
    task automatic await(input int which);
        for (n = 0; n < 20 && !watch[which]; n++) @(posedge clock);
        if (n == 20) begin
            error_cnt++;
            wrap_up();
        end
    endtask : await
    ////////////////////////////////////////////////////////////////
    task automatic boot_seq();
        press <= 1'b1;
        ext_flag_value <= 1'b1;
        await(5);
        repeat (4) @(posedge clock);
        chk(program_counter, 16'h0000);
        chk(sys_ctrl_status_reg_two[3], 1'b1);
        press <= 1'b0;
        await(4);
        chk(program_counter, 16'h0000);
        advance <= 1'b1;
        repeat (3) @(posedge clock);
        advance <= 1'b0;
        @(posedge clock);
        chk(program_counter, 16'h0003);
        chk({external_flag_oe, external_flag_output}, 2'h3);
        chk({15'h0000, |gpio_dir_out}, 16'h0000);
    endtask : boot_seq
    task automatic fault_seq();
        for (int i = 0; i < 2; i++) begin
            want[3-i] <= 1'b0;
            await(3 - i);
            chk(i ? fault_irq_b : fault_irq_a, 1'b1);
            // A line still held low must not fire again after the clear
            {fault_clear_a, fault_clear_b} <= i ? 2'h1 : 2'h2;
            repeat (3) @(posedge clock);
            {fault_clear_a, fault_clear_b} <= 2'h0;
            repeat (8) @(posedge clock);
            chk(i ? pwm_float_b : pwm_float_a, 1'b0);
            want[3-i] <= 1'b1;
        end
    endtask : fault_seq
    task automatic irq_seq();
        for (int p = 0; p < 2; p++) begin
            irq_one_rising <= p[0];
            want[1] <= !p[0];
            repeat (8) @(posedge clock);
            irq_clear_one <= 1'b1;
            @(posedge clock);
            irq_clear_one <= 1'b0;
            want[1] <= p[0];
            await(1);
            chk(user_irq_one_flag, 1'b1);
            irq_clear_one <= 1'b1;
            @(posedge clock);
            irq_clear_one <= 1'b0;
            want[1] <= !p[0];
            repeat (8) @(posedge clock);
            chk(user_irq_one_flag, 1'b0);
        end
        want[0] <= 1'b0;
        for (n = 0; n < 12 && conversion_start_input !== 1'b1; n++) @(posedge clock);
        chk({conversion_start_input, user_irq_two_flag}, 2'h2);
        irq_two_mode_start <= 1'b0;
        irq_two_rising <= 1'b1;
        want[0] <= 1'b1;
        repeat (8) @(posedge clock);
        chk(user_irq_two_flag, 1'b1);
    endtask : irq_seq
    task automatic clk_wd_seq();
        @(posedge clock);
        #5;
        chk(clock_output_pin, 1'b1);
        @(posedge clock);
        sys_ctrl_status_reg <= 16'h4000;
        repeat (2) @(posedge clock);
        #5;
        chk(clock_output_pin, watchdog_tick_clock);
        @(posedge clock);
        boot_enable_pin_in <= 1'b0;
        watchdog_overflow <= 1'b1;
        @(posedge clock);
        watchdog_overflow <= 1'b0;
        await(0);
        await(5);
        await(4);
        chk(program_counter, 16'h0000);
        chk(sys_ctrl_status_reg_two[3], 1'b0);
        boot_enable_pin_in <= 1'b1;
    endtask : clk_wd_seq
    task automatic off_seq();
        test_reset <= 1'b0;
        test_output_disable <= 1'b0;
        repeat (8) @(posedge clock);
        chk({all_outputs_float, oscillator_output_oe}, 2'h2);
        test_reset <= 1'b1;
        repeat (8) @(posedge clock);
        chk(all_outputs_float, 1'b0);
    endtask : off_seq
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        await(4);
        boot_seq();
        fault_seq();
        irq_seq();
        clk_wd_seq();
        off_seq();
        wrap_up();
    end
endmodule : test_system_pin_control_logic
`default_nettype wire
